//--- src/cskip_pkg.sv
// Purpose: shared constants and types for the complement / compare-skip executor
// Assumes: 8-bit data path, 16-bit instruction words, APB register access
// Notes: all offsets are byte addresses of aligned 32-bit words
package cskip_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_INSTR = 12'h000;
  localparam logic [11:0] OFF_ACC = 12'h004;
  localparam logic [11:0] OFF_BANK = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_MEM_ADDR = 12'h010;
  localparam logic [11:0] OFF_MEM_DATA = 12'h014;
  localparam logic [11:0] OFF_CYCLES = 12'h018;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic FLAG_RST = 1'b0;
  localparam int ST_ZERO = 0;
  localparam int ST_NEG = 1;
  localparam int ST_SKIP = 2;
  localparam int ST_BUSY = 3;

  // ----------------------------------------------------------------
  // instruction encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] COMPLEMENT_OPC = 6'h07;    // 0001 11da
  localparam logic [6:0] CMP_EQ_OPC = 7'h31;        // 0110 001a
  localparam logic [3:0] TWO_WORD_MOVE = 4'hC;
  localparam logic [6:0] TWO_WORD_CALL = 7'h76;
  localparam logic [7:0] TWO_WORD_LOAD = 8'hEE;
  localparam logic [7:0] TWO_WORD_JUMP = 8'hEF;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  localparam logic [3:0] CYCLES_MAX = 4'hF;

  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} quarter_t;

  typedef struct packed {
    logic complement_register_op;
    logic compare_skip_equal_op;
    logic dest_reg;
    logic banked;
    logic [7:0] faddr;
  } decoded_t;
endpackage

//--- src/quarter_tick.sv
// Purpose: divider making the quarter-phase enable pulse
// Assumes: run is from the same clock domain
// Notes: counter restarts whenever run is low, so the first quarter is full length
`timescale 1ns/1ps
module quarter_tick #(
  parameter int DIV = 1
) (
  input wire logic pclk,      // system clock
  input wire logic presetn,   // async reset, active low
  input wire logic run,       // instruction in flight
  output logic q_tick         // one-cycle quarter enable
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_q_tick;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // count resets on idle so phases stay aligned to the start
  always_comb begin
    next_cnt = 8'h00;
    next_q_tick = 1'b0;
    if (run) begin
      if (cnt == 8'(DIV - 1)) begin
        next_q_tick = 1'b1;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  // register count and tick so the enable is a clean one-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      q_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      q_tick <= next_q_tick;
    end
  end
endmodule

//--- src/cskip_exec.sv
// Purpose: executes complement-register and compare-skip-if-equal instructions
// Assumes: software feeds instruction words one at a time over APB
// Notes: other opcodes run as one no-operation cycle
//
// How it works
// RQ1: complement op inverts addressed register, updates negative and zero flags.
// RQ2: destination bit clear puts inverted value in accumulator, register untouched.
// RQ3: destination bit set writes inverted value back to the register.
// RQ4: bank bit clear addresses the shared low bank, bank register ignored.
// RQ5: bank bit set addresses bank register joined with 8-bit field.
// RQ6: compare op tests register minus accumulator unsigned, stores nothing.
// RQ7: on equal, next fetched word becomes a no-op; two-word discards both.
// RQ8: complement runs in one cycle: decode, read, process, write quarters.
`timescale 1ns/1ps
module cskip_exec #(
  parameter int BANKS = 16,
  parameter int QDIV = 1
) (
  input wire logic pclk,             // system clock, 50 MHz
  input wire logic presetn,          // async reset, active low
  input wire logic psel,             // apb select
  input wire logic penable,          // apb enable
  input wire logic pwrite,           // apb direction
  input wire logic [11:0] paddr,     // apb byte address
  input wire logic [31:0] pwdata,    // apb write data
  output logic [31:0] prdata,        // apb read data
  output logic pready,               // apb ready
  output logic pslverr               // apb error, unmapped address
);
  localparam int MEM_WORDS = BANKS * 256;

  logic [7:0] mem [MEM_WORDS];
  logic busy, discard, flag_n, flag_z, eq, q_tick;
  logic [1:0] skip_words;
  logic [3:0] bank_select_reg, cycles;
  logic [7:0] acc, operand, result;
  logic [11:0] mem_addr;
  logic [15:0] instr;
  cskip_pkg::quarter_t phase;
  cskip_pkg::decoded_t dec;

  logic next_busy, next_discard, next_flag_n, next_flag_z, next_eq;
  logic next_pready, next_pslverr;
  logic [1:0] next_skip_words;
  logic [3:0] next_bank, next_cycles;
  logic [7:0] next_acc, next_operand, next_result;
  logic [11:0] next_mem_addr;
  logic [15:0] next_instr;
  logic [31:0] next_prdata;
  cskip_pkg::quarter_t next_phase;
  cskip_pkg::decoded_t next_dec;
  logic mem_we;
  logic [11:0] mem_wa, ea;
  logic [7:0] mem_wd;
  logic done, wr_done, stall, mapped, start;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic cskip_pkg::decoded_t decode(input logic [15:0] w);
    cskip_pkg::decoded_t d;
    d.complement_register_op = (w[15:10] == cskip_pkg::COMPLEMENT_OPC); // [RQ1]
    d.compare_skip_equal_op = (w[15:9] == cskip_pkg::CMP_EQ_OPC); // [RQ6]
    d.dest_reg = d.complement_register_op & w[9];
    d.banked = w[8];
    d.faddr = w[7:0];
    return d;
  endfunction

  function automatic logic two_word(input logic [15:0] w);
    return (w[15:12] == cskip_pkg::TWO_WORD_MOVE) || (w[15:9] == cskip_pkg::TWO_WORD_CALL)
      || (w[15:8] == cskip_pkg::TWO_WORD_LOAD) || (w[15:8] == cskip_pkg::TWO_WORD_JUMP);
  endfunction

  quarter_tick #(.DIV(QDIV)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(busy),
    .q_tick(q_tick)
  );

  // ----------------------------------------------------------------
  // effective data address
  // ----------------------------------------------------------------
  // low bank ignores the bank register entirely
  always_comb begin
    if (dec.banked) begin
      ea = {bank_select_reg, dec.faddr}; // [RQ5]
    end else begin
      ea = {cskip_pkg::ACCESS_BANK, dec.faddr}; // [RQ4]
    end
  end

  // ----------------------------------------------------------------
  // bus and execution next state
  // ----------------------------------------------------------------
  // writes wait while busy so a bus write never races a quarter-four write
  always_comb begin
    stall = psel & penable & pwrite & busy;
    done = psel & penable & pready;
    wr_done = done & pwrite;
    start = wr_done & (paddr == cskip_pkg::OFF_INSTR);
    mapped = (paddr == cskip_pkg::OFF_INSTR) || (paddr == cskip_pkg::OFF_ACC)
      || (paddr == cskip_pkg::OFF_BANK) || (paddr == cskip_pkg::OFF_STATUS)
      || (paddr == cskip_pkg::OFF_MEM_ADDR) || (paddr == cskip_pkg::OFF_MEM_DATA)
      || (paddr == cskip_pkg::OFF_CYCLES);
    next_pready = psel & penable & ~pready & ~stall;
    next_pslverr = next_pready & ~mapped;
    next_prdata = 32'h0000_0000;
    if (next_pready & ~pwrite) begin
      unique case (paddr)
        cskip_pkg::OFF_INSTR: next_prdata = {16'h0000, instr};
        cskip_pkg::OFF_ACC: next_prdata = {24'h00_0000, acc};
        cskip_pkg::OFF_BANK: next_prdata = {28'h000_0000, bank_select_reg};
        cskip_pkg::OFF_STATUS: next_prdata = {28'h000_0000, busy, skip_words != 2'b00,
          flag_n, flag_z};
        cskip_pkg::OFF_MEM_ADDR: next_prdata = {20'h0_0000, mem_addr};
        cskip_pkg::OFF_MEM_DATA: next_prdata = {24'h00_0000, mem[mem_addr]};
        cskip_pkg::OFF_CYCLES: next_prdata = {28'h000_0000, cycles};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    next_busy = busy;
    next_discard = discard;
    next_flag_n = flag_n;
    next_flag_z = flag_z;
    next_eq = eq;
    next_skip_words = skip_words;
    next_bank = bank_select_reg;
    next_cycles = cycles;
    next_acc = acc;
    next_operand = operand;
    next_result = result;
    next_mem_addr = mem_addr;
    next_instr = instr;
    next_phase = phase;
    next_dec = dec;
    mem_we = 1'b0;
    mem_wa = mem_addr;
    mem_wd = pwdata[7:0];
    if (wr_done) begin
      unique case (paddr)
        cskip_pkg::OFF_ACC: next_acc = pwdata[7:0];
        cskip_pkg::OFF_BANK: next_bank = pwdata[3:0];
        cskip_pkg::OFF_STATUS: begin
          next_flag_z = pwdata[cskip_pkg::ST_ZERO];
          next_flag_n = pwdata[cskip_pkg::ST_NEG];
        end
        cskip_pkg::OFF_MEM_ADDR: next_mem_addr = pwdata[11:0];
        cskip_pkg::OFF_MEM_DATA: mem_we = 1'b1;
        default: ;
      endcase
    end
    // a discarded word still costs a full cycle of four quarters
    if (start) begin
      next_busy = 1'b1;
      next_phase = cskip_pkg::Q1;
      next_instr = pwdata[15:0];
      next_discard = (skip_words != 2'b00); // [RQ7]
      if (skip_words != 2'b00) begin
        next_skip_words = two_word(pwdata[15:0]) ? 2'b01 : skip_words - 2'b01; // [RQ7]
        next_cycles = (cycles == cskip_pkg::CYCLES_MAX) ? cycles : cycles + 4'h1;
      end else begin
        next_skip_words = two_word(pwdata[15:0]) ? 2'b01 : 2'b00;
        next_cycles = 4'h1;
      end
    end
    if (busy & q_tick) begin
      unique case (phase)
        cskip_pkg::Q1: begin
          next_dec = decode(instr); // [RQ8]
          next_phase = cskip_pkg::Q2;
        end
        cskip_pkg::Q2: begin
          next_operand = mem[ea]; // [RQ8]
          next_phase = cskip_pkg::Q3;
        end
        cskip_pkg::Q3: begin
          next_result = ~operand; // [RQ1]
          next_eq = (operand - acc) == 8'h00; // [RQ6]
          next_phase = cskip_pkg::Q4;
        end
        cskip_pkg::Q4: begin
          next_busy = 1'b0;
          next_phase = cskip_pkg::Q1;
          if (!discard && dec.complement_register_op) begin
            if (dec.dest_reg) begin
              mem_we = 1'b1; // [RQ3]
              mem_wa = ea;
              mem_wd = result;
            end else begin
              next_acc = result; // [RQ2]
            end
            next_flag_n = result[7]; // [RQ1]
            next_flag_z = (result == 8'h00); // [RQ1]
          end
          if (!discard && dec.compare_skip_equal_op && eq) begin
            next_skip_words = 2'b01; // [RQ7]
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // every next_ value lands here, so bus outputs come straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      busy <= 1'b0;
      discard <= 1'b0;
      flag_n <= cskip_pkg::FLAG_RST;
      flag_z <= cskip_pkg::FLAG_RST;
      eq <= 1'b0;
      skip_words <= 2'b00;
      bank_select_reg <= cskip_pkg::BANK_RST;
      cycles <= 4'h0;
      acc <= cskip_pkg::ACC_RST;
      operand <= 8'h00;
      result <= 8'h00;
      mem_addr <= 12'h000;
      instr <= 16'h0000;
      phase <= cskip_pkg::Q1;
      dec <= '0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      busy <= next_busy;
      discard <= next_discard;
      flag_n <= next_flag_n;
      flag_z <= next_flag_z;
      eq <= next_eq;
      skip_words <= next_skip_words;
      bank_select_reg <= next_bank;
      cycles <= next_cycles;
      acc <= next_acc;
      operand <= next_operand;
      result <= next_result;
      mem_addr <= next_mem_addr;
      instr <= next_instr;
      phase <= next_phase;
      dec <= next_dec;
    end
  end

  // data memory has no reset; contents are undefined until written
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic q4_comp;
  assign q4_comp = busy & q_tick & (phase == cskip_pkg::Q4) & ~discard
    & dec.complement_register_op;

  a_comp_flags: assert property (q4_comp |=> (flag_n == $past(result[7])) // [RQ1]
    && (flag_z == ($past(result) == 8'h00))) else $error("flags wrong after complement");
  a_comp_to_acc: assert property (q4_comp & ~dec.dest_reg |=> acc == ~$past(operand)) // [RQ2]
    else $error("accumulator not inverted operand");
  a_comp_to_reg: assert property (q4_comp & dec.dest_reg // [RQ3]
    |=> (mem[$past(ea)] == ~$past(operand)) && $stable(acc))
    else $error("register not written back");
  a_access_low: assert property (busy & ~dec.banked & (phase == cskip_pkg::Q2) // [RQ4]
    |-> ea[11:8] == cskip_pkg::ACCESS_BANK) else $error("low bank not used");
  a_bank_form: assert property (busy & dec.banked & (phase == cskip_pkg::Q2) // [RQ5]
    |-> ea == {bank_select_reg, dec.faddr}) else $error("banked address wrong");
  a_cmp_nostore: assert property (busy & q_tick & (phase == cskip_pkg::Q4) // [RQ6]
    & dec.compare_skip_equal_op |=> $stable(acc) && $stable(flag_n) && $stable(flag_z))
    else $error("compare changed state");
  a_skip_arm: assert property (busy & q_tick & (phase == cskip_pkg::Q4) & ~discard // [RQ7]
    & dec.compare_skip_equal_op & eq |=> skip_words == 2'b01) else $error("skip not armed");
  a_discard_quiet: assert property (busy & discard // [RQ7]
    |-> !(mem_we && !wr_done)) else $error("discarded word wrote memory");
  // a discarded complement must leave accumulator and flags alone as well
  a_discard_keep: assert property (busy & q_tick & (phase == cskip_pkg::Q4) & discard // [RQ7]
    |=> $stable(acc) && $stable(flag_n) && $stable(flag_z)) else $error("discarded word ran");
  a_skip_cycles: assert property (start & (skip_words == 2'b00) |=> cycles == 4'h1) // [RQ7]
    else $error("cycle count not restarted");
  a_quarter_walk: assert property (busy & q_tick & (phase == cskip_pkg::Q1) // [RQ8]
    |=> (phase == cskip_pkg::Q2) && busy) else $error("quarter sequence broken");
  a_single_cycle: assert property (start |=> busy && (phase == cskip_pkg::Q1)) // [RQ8]
    else $error("instruction did not start in quarter one");
endmodule

//--- verification/apb_master.sv
// Purpose: register-bus master standing in for the software side of the executor
// Assumes: one clock, requests launched right after a rising edge
// Notes: every wait is bounded; a timeout is reported back to the caller
`timescale 1ns/1ps
module apb_master (
  input wire logic pclk,            // system clock
  input wire logic pready,          // slave ready
  input wire logic pslverr,         // slave error
  input wire logic [31:0] prdata,   // slave read data
  output logic psel,                // select
  output logic penable,             // enable
  output logic pwrite,              // direction
  output logic [11:0] paddr,        // byte address
  output logic [31:0] pwdata        // write data
);
  // ---------------------------------------------------------------
  // idle bus
  // ---------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end

  // ---------------------------------------------------------------
  // one transfer
  // ---------------------------------------------------------------
  // request held until pready is seen high; writes may stall while busy
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic tmo);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    tmo = (n >= 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

//--- verification/testbench.sv
// Purpose: self-checking bench for the complement and compare-skip executor
// Assumes: quarter divider at 1, data memory written before it is read
// Notes: every scenario is its own task and judges its own results
`timescale 1ns/1ps
module testbench;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int fails = 0;
  int compares = 0;

  cskip_exec #(.BANKS(16), .QDIV(1)) cskip_exec_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  apb_master apb_master_inst (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic end_of_test();
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // a stuck bus ends the run at once
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    logic t;
    apb_master_inst.xfer(w, a, d, q, e, t);
    if (t) begin
      fails++;
      $display("[FAIL] %0t bus timeout", $time);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bus(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    logic e;
    bus(1'b0, a, 32'h00000000, q, e);
    chk(q, exp, msg);
  endtask

  task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
    wr(cskip_pkg::OFF_MEM_ADDR, {20'h00000, a});
    wr(cskip_pkg::OFF_MEM_DATA, {24'h000000, d});
  endtask

  task automatic mem_rd(input logic [11:0] a, input logic [7:0] exp, input string msg);
    wr(cskip_pkg::OFF_MEM_ADDR, {20'h00000, a});
    rd(cskip_pkg::OFF_MEM_DATA, {24'h000000, exp}, msg);
  endtask

  // issue one instruction word, then poll busy with a bounded count
  task automatic run(input logic [15:0] w);
    logic [31:0] q;
    logic e;
    int i;
    wr(cskip_pkg::OFF_INSTR, {16'h0000, w});
    for (i = 0; i < 20; i++) begin
      bus(1'b0, cskip_pkg::OFF_STATUS, 32'h00000000, q, e);
      if (q[cskip_pkg::ST_BUSY] === 1'b0) break;
    end
    if (i == 20) begin
      fails++;
      $display("[FAIL] %0t busy never cleared", $time);
      end_of_test();
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic reset_and_map();
    logic [31:0] q;
    logic e;
    rd(cskip_pkg::OFF_ACC, 32'h00000000, "acc reset");
    rd(cskip_pkg::OFF_STATUS, 32'h00000000, "status reset");
    rd(cskip_pkg::OFF_CYCLES, 32'h00000000, "cycles reset");
    bus(1'b0, 12'h01C, 32'h00000000, q, e);
    chk({31'h00000000, e}, 32'h00000001, "unmapped error");
    chk(q, 32'h00000000, "unmapped data");
    bus(1'b0, cskip_pkg::OFF_BANK, 32'h00000000, q, e);
    chk({31'h00000000, e}, 32'h00000000, "mapped read error");
    chk(q, 32'h00000000, "bank reset");
  endtask

  // banked write-back: 0x13 must come back as 0xEC
  task automatic complement_to_reg();
    wr(cskip_pkg::OFF_BANK, 32'h00000003);
    mem_wr(12'h345, 8'h13);
    mem_wr(12'h045, 8'hFF);
    run(16'h1F45);
    mem_rd(12'h345, 8'hEC, "inverted write-back");
    rd(cskip_pkg::OFF_STATUS, 32'h00000002, "negative flag");
    rd(cskip_pkg::OFF_CYCLES, 32'h00000001, "single cycle");
    rd(cskip_pkg::OFF_ACC, 32'h00000000, "acc untouched");
  endtask

  // low bank reached although bank register holds 3
  task automatic complement_to_acc();
    wr(cskip_pkg::OFF_ACC, 32'h0000005A);
    run(16'h1C45);
    rd(cskip_pkg::OFF_ACC, 32'h00000000, "acc gets inverse");
    rd(cskip_pkg::OFF_STATUS, 32'h00000001, "zero flag");
    mem_rd(12'h045, 8'hFF, "source kept");
    mem_rd(12'h345, 8'hEC, "other bank kept");
  endtask

  task automatic compare_skip();
    wr(cskip_pkg::OFF_ACC, 32'h000000EC);
    run(16'h6345);
    rd(cskip_pkg::OFF_STATUS, 32'h00000005, "skip pending, flags kept");
    mem_rd(12'h345, 8'hEC, "compare stores nothing");
    run(16'h1D45);
    rd(cskip_pkg::OFF_ACC, 32'h000000EC, "skipped word discarded");
    rd(cskip_pkg::OFF_CYCLES, 32'h00000002, "two cycles");
    run(16'h6345);
    run(16'hEE00);
    run(16'h1D45);
    rd(cskip_pkg::OFF_ACC, 32'h000000EC, "two-word discarded");
    rd(cskip_pkg::OFF_CYCLES, 32'h00000003, "three cycles");
    wr(cskip_pkg::OFF_ACC, 32'h00000000);
    run(16'h6345);
    rd(cskip_pkg::OFF_STATUS, 32'h00000001, "no skip when unequal");
    run(16'h1D45);
    rd(cskip_pkg::OFF_ACC, 32'h00000013, "next word runs");
    rd(cskip_pkg::OFF_STATUS, 32'h00000000, "flags cleared");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    reset_and_map();
    complement_to_reg();
    complement_to_acc();
    compare_skip();
    end_of_test();
  end
endmodule
